// [inc/line_link_map.svh]
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, 50 MHz ref_clk
// Notes: included by its bare name
//
// Notes on behaviour
// - Device interrupt enables: 0 blocks a source, 1 passes it to irq.
// - Sink current bits 7:6 pick 200/244/288/355 mA; reset code 2.
// - Unit time bits 5:4 pick 6/24/192/1536 us; reset code 1.
// - Parity bits 3:2: 1 odd, 2 even, 0 and 3 no parity.
// - Send code 1 sends 0x0D, 2 sends 0x0E-0x0F, 3 all three.
// - Send field returns to 00 by itself when transmission ends.
// - Status bit 7: receive wait timer expired, master mode only.
// - Status bits 6/5 send error/success, cleared by each new send.
// - Status bit 4 is 1 exactly while a transmission is in progress.
// - Status bit 3 set on any receive error.
// - Status bit 2 set by byte into 0x10, cleared by reading 0x10.
// - Status bit 1 set when two new bytes land in 0x11 and 0x12.
// - Status bit 0 rises on valid signal, falls after 4 idle bits.
// - Interrupt bit 7 latches wait timeout; reading register clears all.
// - Interrupt bits 6/5 latch send error/success until read.
// - Link mask at 0xC, same layout, 1 lets interrupt through.
`ifndef LINE_LINK_MAP_SVH
`define LINE_LINK_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFF_DEV_FLAGS 8'h07
`define OFF_DEV_MASK 8'h08
`define OFF_CTRL 8'h09
`define OFF_STATUS 8'h0A
`define OFF_IRQ 8'h0B
`define OFF_LINK_MASK 8'h0C
`define OFF_TX0 8'h0D
`define OFF_TX1 8'h0E
`define OFF_TX2 8'h0F
`define OFF_RX0 8'h10
`define OFF_RX1 8'h11
`define OFF_RX2 8'h12

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define CTRL_SINK_HI 7
`define CTRL_SINK_LO 6
`define CTRL_UNIT_HI 5
`define CTRL_UNIT_LO 4
`define CTRL_PAR_HI 3
`define CTRL_PAR_LO 2
`define CTRL_SEND_HI 1
`define CTRL_SEND_LO 0
`define RST_SINK 2'h2
`define RST_UNIT 2'h1
`define RST_PAR 2'h1
`define RST_DEV_MASK 8'h10
`define DEV_MASK_USED 8'h7F
`define ST_WAIT 7
`define ST_ERR 6
`define ST_OK 5
`define ST_BUSY 4
`define ST_RXERR 3
`define ST_ONE 2
`define ST_TWO 1
`define ST_ACT 0

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 20
`define UNIT0_NS 6000
`define UNIT1_NS 24000
`define UNIT2_NS 192000
`define UNIT3_NS 1536000
`define UNIT0_CYC (`UNIT0_NS / `CLK_PERIOD_NS)
`define UNIT1_CYC (`UNIT1_NS / `CLK_PERIOD_NS)
`define UNIT2_CYC (`UNIT2_NS / `CLK_PERIOD_NS)
`define UNIT3_CYC (`UNIT3_NS / `CLK_PERIOD_NS)
`define IDLE_BITS 3'h4

`endif

// [inc/line_link_pkg.sv]
// Purpose: shared types of the powerline link register bank
// Assumes: nothing beyond SystemVerilog
// Notes: constants live in line_link_map.svh
package line_link_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_BUSY = 2'b10
    } tx_state_t;
    typedef enum logic [1:0] {
        PAR_OFF = 2'h0,
        PAR_ODD = 2'h1,
        PAR_EVEN = 2'h2,
        PAR_OFF2 = 2'h3
    } parity_t;
    typedef enum logic [1:0] {
        SEND_NONE = 2'h0,
        SEND_FIRST = 2'h1,
        SEND_PAIR = 2'h2,
        SEND_ALL = 2'h3
    } send_cmd_t;
endpackage

// [rtl/line_link_regs.sv]
// Purpose: control and status registers of a DC powerline byte link
// Assumes: link engine runs on ref_clk; master strap is asynchronous
// Notes: registers read one cycle after the read strobe
`include "line_link_map.svh"

module line_link_regs #(
    parameter int unsigned CNT_W = 17,
    parameter int unsigned UNIT0 = `UNIT0_CYC,
    parameter int unsigned UNIT1 = `UNIT1_CYC,
    parameter int unsigned UNIT2 = `UNIT2_CYC,
    parameter int unsigned UNIT3 = `UNIT3_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [7:0] rdata,
    // Interrupt
    output logic irq_out,
    input wire logic [6:0] dev_event,
    // Mode strap
    input wire logic master_mode_pin,
    // Transmit side of the link engine
    output logic tx_start,
    output line_link_pkg::send_cmd_t tx_cmd,
    output logic [7:0] tx_byte0,
    output logic [7:0] tx_byte1,
    output logic [7:0] tx_byte2,
    input wire logic tx_done,
    input wire logic tx_fail,
    // Receive side of the link engine
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte0,
    input wire logic rx_pair_valid,
    input wire logic [7:0] rx_byte1,
    input wire logic [7:0] rx_byte2,
    input wire logic rx_error,
    input wire logic rx_wait_expired,
    input wire logic signal_valid,
    // Link settings and bit unit tick
    output logic [1:0] sink_current,
    output logic [1:0] unit_time,
    output line_link_pkg::parity_t parity_mode,
    output logic unit_tick
);
    import line_link_pkg::*;

    if (UNIT0 < 1 || UNIT1 < 1 || UNIT2 < 1 || UNIT3 < 1) begin : g_zero
        $error("unit counts must be at least one cycle");
    end
    if (CNT_W > 31 || UNIT3 > (1 << CNT_W) || UNIT2 > (1 << CNT_W) ||
        UNIT1 > (1 << CNT_W) || UNIT0 > (1 << CNT_W)) begin : g_wide
        $error("CNT_W too narrow for the unit counts");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [CNT_W-1:0] unit_limit(input logic [1:0] c);
        case (c)
            2'h0: unit_limit = CNT_W'(UNIT0 - 1);
            2'h1: unit_limit = CNT_W'(UNIT1 - 1);
            2'h2: unit_limit = CNT_W'(UNIT2 - 1);
            default: unit_limit = CNT_W'(UNIT3 - 1);
        endcase
    endfunction

    function automatic logic hit(input logic s, input logic [7:0] a,
                                 input logic [7:0] off);
        hit = s && (a == off);
    endfunction

    logic master_meta_q, master_q;
    logic [7:0] dev_mask_q, link_mask_q, dev_flags_q, link_flags_q;
    logic [7:0] rx0_q, rx1_q, rx2_q, status, prev_status_q, rd_mux;
    logic [1:0] send_field_q;
    logic [CNT_W-1:0] unit_cnt_q;
    logic [2:0] idle_q;
    logic wait_q, err_q, ok_q, rxerr_q, one_q, two_q, act_q;
    tx_state_t tx_state_q;

    logic wr_ctrl, rd_irq, rd_dev, start_ok;
    assign wr_ctrl = hit(wr_strobe, addr, `OFF_CTRL);
    assign rd_irq = hit(rd_strobe, addr, `OFF_IRQ);
    assign rd_dev = hit(rd_strobe, addr, `OFF_DEV_FLAGS);
    assign start_ok = wr_ctrl && (tx_state_q == TX_IDLE) &&
                      (wdata[`CTRL_SEND_HI:`CTRL_SEND_LO] != 2'h0);

    // ****************************************************************
    // Strap synchroniser
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            master_meta_q <= 1'b0;
            master_q <= 1'b0;
        end else begin
            master_meta_q <= master_mode_pin;
            master_q <= master_meta_q;
        end
    end

    // ****************************************************************
    // Settings and data registers
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sink_current <= `RST_SINK;
            unit_time <= `RST_UNIT;
            parity_mode <= parity_t'(`RST_PAR);
            dev_mask_q <= `RST_DEV_MASK;
            link_mask_q <= 8'h00;
            tx_byte0 <= 8'h00;
            tx_byte1 <= 8'h00;
            tx_byte2 <= 8'h00;
        end else if (wr_strobe) begin
            case (addr)
                `OFF_CTRL: begin
                    sink_current <= wdata[`CTRL_SINK_HI:`CTRL_SINK_LO];
                    unit_time <= wdata[`CTRL_UNIT_HI:`CTRL_UNIT_LO];
                    parity_mode <= parity_t'(
                        wdata[`CTRL_PAR_HI:`CTRL_PAR_LO]);
                end
                `OFF_DEV_MASK: dev_mask_q <= wdata & `DEV_MASK_USED;
                `OFF_LINK_MASK: link_mask_q <= wdata;
                `OFF_TX0: tx_byte0 <= wdata;
                `OFF_TX1: tx_byte1 <= wdata;
                `OFF_TX2: tx_byte2 <= wdata;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Send sequencing
    // ****************************************************************
    // A send written while busy is dropped: the engine takes one at a time
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_state_q <= TX_IDLE;
            send_field_q <= 2'h0;
            tx_start <= 1'b0;
            tx_cmd <= SEND_NONE;
        end else begin
            tx_start <= 1'b0;
            case (tx_state_q)
                TX_IDLE: begin
                    if (start_ok) begin
                        tx_state_q <= TX_BUSY;
                        send_field_q <=
                            wdata[`CTRL_SEND_HI:`CTRL_SEND_LO];
                        tx_cmd <= send_cmd_t'(
                            wdata[`CTRL_SEND_HI:`CTRL_SEND_LO]);
                        tx_start <= 1'b1;
                    end
                end
                TX_BUSY: begin
                    if (tx_done || tx_fail) begin
                        tx_state_q <= TX_IDLE;
                        send_field_q <= 2'h0;
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_q <= 1'b0;
            ok_q <= 1'b0;
        end else if (start_ok) begin
            err_q <= 1'b0;
            ok_q <= 1'b0;
        end else if (tx_state_q == TX_BUSY) begin
            if (tx_fail) begin
                err_q <= 1'b1;
            end else if (tx_done) begin
                ok_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Receive status
    // ****************************************************************
    // Set wins over a read clear in the same cycle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx0_q <= 8'h00;
            rx1_q <= 8'h00;
            rx2_q <= 8'h00;
            one_q <= 1'b0;
            two_q <= 1'b0;
            rxerr_q <= 1'b0;
            wait_q <= 1'b0;
        end else begin
            if (rx_byte_valid) begin
                rx0_q <= rx_byte0;
            end
            if (rx_pair_valid) begin
                rx1_q <= rx_byte1;
                rx2_q <= rx_byte2;
            end
            one_q <= rx_byte_valid ||
                     (one_q && !hit(rd_strobe, addr, `OFF_RX0));
            two_q <= rx_pair_valid ||
                     (two_q && !hit(rd_strobe, addr, `OFF_RX2));
            if (rx_error) begin
                rxerr_q <= 1'b1;
            end else if (rx_byte_valid || rx_pair_valid) begin
                rxerr_q <= 1'b0;
            end
            wait_q <= master_q && rx_wait_expired;
        end
    end

    // ****************************************************************
    // Bit unit timing and line activity
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            unit_cnt_q <= '0;
            unit_tick <= 1'b0;
        end else if (unit_cnt_q >= unit_limit(unit_time)) begin
            unit_cnt_q <= '0;
            unit_tick <= 1'b1;
        end else begin
            unit_cnt_q <= unit_cnt_q + 1'b1;
            unit_tick <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            act_q <= 1'b0;
            idle_q <= 3'h0;
        end else if (signal_valid) begin
            act_q <= 1'b1;
            idle_q <= 3'h0;
        end else if (unit_tick && act_q) begin
            if (idle_q == `IDLE_BITS - 3'h1) begin
                act_q <= 1'b0;
                idle_q <= 3'h0;
            end else begin
                idle_q <= idle_q + 3'h1;
            end
        end
    end

    // ****************************************************************
    // Interrupt flags
    // ****************************************************************
    assign status = {wait_q, err_q, ok_q, tx_state_q == TX_BUSY,
                     rxerr_q, one_q, two_q, act_q};

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_status_q <= 8'h00;
            link_flags_q <= 8'h00;
            dev_flags_q <= 8'h00;
        end else begin
            prev_status_q <= status;
            link_flags_q <= (rd_irq ? 8'h00 : link_flags_q) |
                            (status & ~prev_status_q);
            dev_flags_q <= (rd_dev ? 8'h00 : dev_flags_q) |
                           {1'b0, dev_event};
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(link_flags_q & link_mask_q) ||
                       |(dev_flags_q & dev_mask_q);
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    always_comb begin
        case (addr)
            `OFF_DEV_FLAGS: rd_mux = dev_flags_q;
            `OFF_DEV_MASK: rd_mux = dev_mask_q;
            `OFF_CTRL: rd_mux = {sink_current, unit_time,
                                 parity_mode, send_field_q};
            `OFF_STATUS: rd_mux = status;
            `OFF_IRQ: rd_mux = link_flags_q;
            `OFF_LINK_MASK: rd_mux = link_mask_q;
            `OFF_TX0: rd_mux = tx_byte0;
            `OFF_TX1: rd_mux = tx_byte1;
            `OFF_TX2: rd_mux = tx_byte2;
            `OFF_RX0: rd_mux = rx0_q;
            `OFF_RX1: rd_mux = rx1_q;
            `OFF_RX2: rd_mux = rx2_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd_strobe ? rd_mux : 8'h00;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    send_start_a: assert property (start_ok |=> tx_start &&
        tx_cmd == send_cmd_t'($past(wdata[1:0])))
        else $error("send not started with written code");
    send_clear_a: assert property (
        tx_state_q == TX_BUSY && tx_done |=> send_field_q == 2'h0)
        else $error("send field not cleared after transmission");
    flags_new_a: assert property (tx_start |-> !ok_q && !err_q)
        else $error("send flags not cleared by new send");
    busy_span_a: assert property (start_ok ##1 !(tx_done || tx_fail)
        |=> status[`ST_BUSY])
        else $error("busy flag dropped during transmission");
    wait_master_a: assert property (!master_q |=> !status[`ST_WAIT])
        else $error("wait timeout shown outside master mode");
    rx_err_a: assert property (rx_error |=> status[`ST_RXERR])
        else $error("receive error not flagged");
    one_byte_a: assert property (hit(rd_strobe, addr, 8'h10) &&
        !rx_byte_valid |=> !one_q)
        else $error("first byte flag not cleared by read");
    two_byte_a: assert property (rx_pair_valid |=> two_q)
        else $error("two byte flag not set");
    idle_drop_a: assert property (act_q && !signal_valid &&
        unit_tick && idle_q == 3'h3 |=> !act_q)
        else $error("activity not dropped after idle bits");
    irq_clear_a: assert property (rd_irq &&
        (status & ~prev_status_q) == 8'h00 |=> link_flags_q == 8'h00)
        else $error("interrupt read did not clear flags");
    ok_latch_a: assert property (ok_q && !$past(ok_q)
        |=> link_flags_q[`ST_OK])
        else $error("success interrupt not latched");
    irq_level_a: assert property (irq_out == $past(
        |(link_flags_q & link_mask_q) || |(dev_flags_q & dev_mask_q)))
        else $error("irq output does not track pending flags");
    mask_gate_a: assert property (link_mask_q == 8'h00 &&
        dev_mask_q == 8'h00 ##1 link_mask_q == 8'h00 &&
        dev_mask_q == 8'h00 |-> !irq_out)
        else $error("masked sources reach irq output");
    sink_write_a: assert property (wr_ctrl |=>
        sink_current == $past(wdata[7:6]))
        else $error("sink current not updated");

    send_done_c: cover property (tx_start ##[1:50] tx_done);
    byte_read_c: cover property (rx_byte_valid ##[1:20] rd_strobe);
    irq_rise_c: cover property ($rose(irq_out));
    act_fall_c: cover property ($fell(act_q));
endmodule

// [sim/link_peer_model.sv]
// Purpose: behavioural link engine standing beyond the register bank
// Assumes: one send at a time, started by a one-cycle tx_start
// Notes: fail_next turns the next finished send into a failed one
module link_peer_model
    import line_link_pkg::*;
#(
    parameter int unsigned BYTE_CYC = 6
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // From the register bank
    input wire logic tx_start,
    input wire line_link_pkg::send_cmd_t tx_cmd,
    input wire logic [7:0] tx_byte0,
    input wire logic [7:0] tx_byte1,
    input wire logic [7:0] tx_byte2,
    input wire logic fail_next,
    // Answers and records
    output logic tx_done,
    output logic tx_fail,
    output logic [23:0] sent_q,
    output logic [7:0] starts_q
);
    logic [9:0] left_q;
    logic busy_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            left_q <= 10'h000;
            tx_done <= 1'b0;
            tx_fail <= 1'b0;
            sent_q <= 24'h000000;
            starts_q <= 8'h00;
        end else begin
            tx_done <= 1'b0;
            tx_fail <= 1'b0;
            if (tx_start && !busy_q) begin
                busy_q <= 1'b1;
                starts_q <= starts_q + 8'h01;
                case (tx_cmd)
                    SEND_FIRST: begin
                        sent_q <= {16'h0000, tx_byte0};
                        left_q <= 10'(BYTE_CYC);
                    end
                    SEND_PAIR: begin
                        sent_q <= {8'h00, tx_byte1, tx_byte2};
                        left_q <= 10'(2 * BYTE_CYC);
                    end
                    default: begin
                        sent_q <= {tx_byte0, tx_byte1, tx_byte2};
                        left_q <= 10'(3 * BYTE_CYC);
                    end
                endcase
            end else if (busy_q) begin
                // Line time grows with the byte count
                if (left_q == 10'h001) begin
                    busy_q <= 1'b0;
                    tx_done <= !fail_next;
                    tx_fail <= fail_next;
                end
                left_q <= left_q - 10'h001;
            end
        end
    end
endmodule

// [sim/testbench.sv]
// Purpose: self-checking bench for the link register bank
// Assumes: link engine replaced by link_peer_model
// Notes: unit times shortened to a few cycles
`include "line_link_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import line_link_pkg::*;

    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic wr_strobe = 1'b0, rd_strobe = 1'b0, irq_out;
    logic [6:0] dev_event = 7'h00;
    logic master_mode_pin = 1'b1, fail_next = 1'b0;
    logic tx_start, tx_done, tx_fail, unit_tick;
    send_cmd_t tx_cmd;
    parity_t parity_mode;
    logic [7:0] tx_byte0, tx_byte1, tx_byte2, starts;
    logic rx_byte_valid = 1'b0, rx_pair_valid = 1'b0, rx_error = 1'b0;
    logic [7:0] rx_byte0 = 8'h00, rx_byte1 = 8'h00, rx_byte2 = 8'h00;
    logic rx_wait_expired = 1'b0, signal_valid = 1'b0;
    logic [1:0] sink_current, unit_time;
    logic [23:0] sent;
    int fails = 0, total_checks = 0, cycles = 0;

    line_link_regs #(.UNIT0(4), .UNIT1(5), .UNIT2(6), .UNIT3(7))
    u_line_link_regs (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr),
        .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .rdata(rdata), .irq_out(irq_out), .dev_event(dev_event),
        .master_mode_pin(master_mode_pin), .tx_start(tx_start),
        .tx_cmd(tx_cmd), .tx_byte0(tx_byte0), .tx_byte1(tx_byte1),
        .tx_byte2(tx_byte2), .tx_done(tx_done), .tx_fail(tx_fail),
        .rx_byte_valid(rx_byte_valid), .rx_byte0(rx_byte0),
        .rx_pair_valid(rx_pair_valid), .rx_byte1(rx_byte1),
        .rx_byte2(rx_byte2), .rx_error(rx_error),
        .rx_wait_expired(rx_wait_expired), .signal_valid(signal_valid),
        .sink_current(sink_current), .unit_time(unit_time),
        .parity_mode(parity_mode), .unit_tick(unit_tick));

    link_peer_model u_link_peer_model (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .tx_start(tx_start), .tx_cmd(tx_cmd),
        .tx_byte0(tx_byte0), .tx_byte1(tx_byte1), .tx_byte2(tx_byte2),
        .fail_next(fail_next), .tx_done(tx_done), .tx_fail(tx_fail),
        .sent_q(sent), .starts_q(starts));

    always #10 ref_clk = ~ref_clk;

    // ****************************************************************
    // Access and checking tasks
    // ****************************************************************
    task automatic tally_and_finish;
        if (fails == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge ref_clk);
        wr_strobe <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge ref_clk);
        rd_strobe <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk(input string n, input logic [23:0] e,
                       input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rdchk(input string n, input logic [7:0] a,
                         input logic [7:0] m, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(n, {16'h0000, e}, {16'h0000, v & m});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Polls instead of assuming the engine's send length
    task automatic wait_idle;
        logic [7:0] v;
        v = 8'h10;
        for (int i = 0; i < 40 && v[4] !== 1'b0; i++)
            rd(`OFF_STATUS, v);
        chk("send finished", 24'h0, {16'h0000, v & 8'h10});
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish;
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [7:0] v;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdchk("ctrl reset", `OFF_CTRL, 8'hFF, 8'h94);
        rdchk("status reset", `OFF_STATUS, 8'hFF, 8'h00);
        rdchk("flags reset", `OFF_IRQ, 8'hFF, 8'h00);
        rdchk("dev mask reset", `OFF_DEV_MASK, 8'hFF, 8'h10);
        rdchk("link mask reset", `OFF_LINK_MASK, 8'hFF, 8'h00);
        rdchk("unmapped", 8'h3F, 8'hFF, 8'h00);
        wr(`OFF_DEV_MASK, 8'hFF);
        rdchk("dev mask top", `OFF_DEV_MASK, 8'hFF, 8'h7F);
        wr(`OFF_STATUS, 8'hFF);
        rdchk("status read only", `OFF_STATUS, 8'hFF, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = {i[1:0], i[1:0], i[1:0], 2'b00};
            wr(`OFF_CTRL, v);
            chk("sink", {22'h0, v[7:6]}, {22'h0, sink_current});
            chk("unit", {22'h0, v[5:4]}, {22'h0, unit_time});
            chk("parity", {22'h0, v[3:2]}, {22'h0, parity_mode});
            rdchk("ctrl", `OFF_CTRL, 8'hFF, v);
        end
        wr(`OFF_CTRL, 8'h94);
        @(posedge unit_tick);
        cyc(4);
        chk("tick gap", 24'h0, {23'h0, unit_tick});
        cyc(1);
        chk("tick", 24'h1, {23'h0, unit_tick});
        wr(`OFF_TX0, 8'hA1);
        wr(`OFF_TX1, 8'hB2);
        wr(`OFF_TX2, 8'hC3);
        wr(`OFF_LINK_MASK, 8'h60);
        // Middle send fails, so the next one must clear the error
        for (int c = 1; c < 4; c++) begin
            fail_next <= (c == 2);
            wr(`OFF_CTRL, 8'h94 | c[7:0]);
            rdchk("busy", `OFF_STATUS, 8'h70, 8'h10);
            wait_idle;
            rdchk("send cleared", `OFF_CTRL, 8'hFF, 8'h94);
            rdchk("outcome", `OFF_STATUS, 8'h60,
                  (c == 2) ? 8'h40 : 8'h20);
            chk("sent", (c == 1) ? 24'h0000A1 : (c == 2) ? 24'h00B2C3 :
                24'hA1B2C3, sent);
            chk("irq", 24'h1, {23'h0, irq_out});
            rdchk("flags", `OFF_IRQ, 8'h60,
                  (c == 2) ? 8'h40 : 8'h20);
            cyc(2);
            chk("irq clear", 24'h0, {23'h0, irq_out});
        end
        fail_next <= 1'b0;
        wr(`OFF_CTRL, 8'h94);
        cyc(4);
        chk("no send", 24'd3, {16'h0000, starts});
        wr(`OFF_LINK_MASK, 8'h00);
        wr(`OFF_CTRL, 8'h95);
        wait_idle;
        chk("masked irq", 24'h0, {23'h0, irq_out});
        rdchk("masked flag", `OFF_IRQ, 8'h20, 8'h20);
        wr(`OFF_LINK_MASK, 8'h80);
        @(posedge ref_clk);
        rx_byte0 <= 8'h5A;
        rx_byte_valid <= 1'b1;
        @(posedge ref_clk);
        rx_byte_valid <= 1'b0;
        rdchk("one byte", `OFF_STATUS, 8'h04, 8'h04);
        rdchk("rx byte", `OFF_RX0, 8'hFF, 8'h5A);
        rdchk("one cleared", `OFF_STATUS, 8'h04, 8'h00);
        @(posedge ref_clk);
        rx_byte1 <= 8'h3C;
        rx_byte2 <= 8'hC3;
        rx_pair_valid <= 1'b1;
        @(posedge ref_clk);
        rx_pair_valid <= 1'b0;
        rdchk("two bytes", `OFF_STATUS, 8'h02, 8'h02);
        rdchk("rx second", `OFF_RX1, 8'hFF, 8'h3C);
        rdchk("rx third", `OFF_RX2, 8'hFF, 8'hC3);
        @(posedge ref_clk);
        rx_error <= 1'b1;
        @(posedge ref_clk);
        rx_error <= 1'b0;
        rdchk("rx error", `OFF_STATUS, 8'h08, 8'h08);
        @(posedge ref_clk);
        rx_wait_expired <= 1'b1;
        rdchk("timer", `OFF_STATUS, 8'h80, 8'h80);
        cyc(2);
        chk("timer irq", 24'h1, {23'h0, irq_out});
        rdchk("timer flag", `OFF_IRQ, 8'h80, 8'h80);
        rdchk("flags cleared", `OFF_IRQ, 8'hFF, 8'h00);
        @(posedge ref_clk);
        master_mode_pin <= 1'b0;
        cyc(4);
        rdchk("slave timer", `OFF_STATUS, 8'h80, 8'h00);
        @(posedge ref_clk);
        rx_wait_expired <= 1'b0;
        signal_valid <= 1'b1;
        rdchk("active", `OFF_STATUS, 8'h01, 8'h01);
        @(posedge ref_clk);
        signal_valid <= 1'b0;
        rdchk("still active", `OFF_STATUS, 8'h01, 8'h01);
        cyc(30);
        rdchk("quiet", `OFF_STATUS, 8'h01, 8'h00);
        wr(`OFF_LINK_MASK, 8'h00);
        rd(`OFF_IRQ, v);
        for (int n = 0; n < 7; n++) begin
            wr(`OFF_DEV_MASK, 8'h01 << n);
            @(posedge ref_clk);
            dev_event <= 7'h01 << n;
            @(posedge ref_clk);
            dev_event <= 7'h00;
            cyc(3);
            chk("dev irq", 24'h1, {23'h0, irq_out});
            rdchk("dev flag", `OFF_DEV_FLAGS, 8'hFF, 8'h01 << n);
            cyc(2);
            chk("dev irq clear", 24'h0, {23'h0, irq_out});
        end
        wr(`OFF_DEV_MASK, 8'h00);
        @(posedge ref_clk);
        dev_event <= 7'h7F;
        @(posedge ref_clk);
        dev_event <= 7'h00;
        cyc(3);
        chk("dev masked", 24'h0, {23'h0, irq_out});
        rdchk("dev flags", `OFF_DEV_FLAGS, 8'hFF, 8'h7F);
        tally_and_finish;
    end
endmodule
